// file: verilog/hpts_search.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module hpts_search (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Search request from the translation logic.
  input wire logic srch_start_i,
  input wire logic [51:0] virtual_segment_id_i,
  input wire logic [15:0] page_index_i,
  input wire logic [5:0] abbreviated_page_index_i,
  output logic srch_busy_o,
  output logic srch_done_o,
  output logic srch_hit_o,
  output logic srch_fault_o,
  output logic [63:0] hit_entry_addr_o,
  // Entry fetch port toward memory, fields already decoded.
  output logic mem_req_o,
  output logic [63:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic ent_valid_i,
  input wire logic ent_hash_sel_i,
  input wire logic [51:0] ent_segment_id_i,
  input wire logic [5:0] ent_page_index_i
);
  //////////////////////////////////////////////////////////////////////
  // Registers.
  logic [45:0] org_q;
  logic [4:0] size_q;
  logic [8:0] mask32_q;
  logic mode64_q;
  logic [31:0] rdata_q;
  hpts_pkg::hpts_state_t state_q;
  logic sec_q;
  logic [2:0] slot_q;
  logic [38:0] hash_q;
  logic m64_q;
  logic [51:0] virtual_segment_id_q;
  logic [5:0] api_q;
  logic [63:0] addr_q;
  logic done_q;
  logic hit_q;
  logic fault_q;
  logic [63:0] hit_addr_q;

  //////////////////////////////////////////////////////////////////////
  // Register decode and read mux.
  wire wr_org_hi = reg_wr_i && (reg_addr_i == hpts_pkg::ORG_HI_OFF);
  wire wr_org_lo = reg_wr_i && (reg_addr_i == hpts_pkg::ORG_LO_OFF);
  wire wr_ctrl = reg_wr_i && (reg_addr_i == hpts_pkg::CTRL_OFF);
  wire [31:0] ctrl_word = {7'h00, mask32_q, 3'h0, size_q, 7'h00, mode64_q};
  wire [31:0] stat_word = {24'h000000, 1'b0, slot_q, sec_q, hit_q, fault_q,
    (state_q == hpts_pkg::HPTS_FETCH)};
  wire [31:0] rd_mux =
    (reg_addr_i == hpts_pkg::ORG_HI_OFF) ? org_q[45:14] :
    (reg_addr_i == hpts_pkg::ORG_LO_OFF) ? {18'h00000, org_q[13:0]} :
    (reg_addr_i == hpts_pkg::CTRL_OFF) ? ctrl_word :
    (reg_addr_i == hpts_pkg::STAT_OFF) ? stat_word : 32'h00000000;

  // Configuration writes; unmapped offsets read as zero.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      org_q <= hpts_pkg::ORG_RST;
      size_q <= hpts_pkg::SIZE_RST;
      mask32_q <= hpts_pkg::MASK_RST;
      mode64_q <= hpts_pkg::MODE_RST;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      if (wr_org_hi)
        org_q[45:14] <= reg_wdata_i;
      if (wr_org_lo)
        org_q[13:0] <= reg_wdata_i[13:0];
      if (wr_ctrl)
      begin
        mode64_q <= reg_wdata_i[hpts_pkg::CTRL_MODE_BIT];
        size_q <= reg_wdata_i[hpts_pkg::CTRL_SIZE_LSB +: 5];
        mask32_q <= reg_wdata_i[hpts_pkg::CTRL_MASK_LSB +: 9];
      end
      rdata_q <= reg_rd_i ? rd_mux : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Hash functions, taken from the request operands.
  // Big-endian bit b of an n-bit field is index n-1-b here.
  wire [38:0] hash64 = virtual_segment_id_i[38:0] ^ {23'h000000, page_index_i};
  wire [38:0] hash32 = {20'h00000,
    virtual_segment_id_i[18:0] ^ {3'h0, page_index_i}};
  wire [38:0] hash_new = mode64_q ? hash64 : hash32;

  // Size code N becomes N low ones of the 28-bit mask, one bit per loop pass.
  wire [27:0] mask64;
  for (genvar gi = 0; gi < hpts_pkg::HI64_W; gi++)
  begin : g_mask_bit
    assign mask64[gi] = (gi < int'(size_q));
  end

  // Group address from a hash value; used for both groups.
  function automatic logic [63:0] grp_addr(input logic [38:0] h, input logic m64,
    input logic [45:0] org, input logic [27:0] mk64, input logic [8:0] mk32);
    logic [63:0] a;
    a = 64'h0;
    if (m64)
    begin
      a[63:18] = org | {18'h00000, h[38:11] & mk64};
      a[17:7] = h[10:0];
      a[6:0] = 7'h00;
    end
    else
    begin
      a[31:16] = org[15:0] | {7'h00, h[18:10] & mk32};
      a[15:6] = h[9:0];
      a[5:0] = 6'h00;
    end
    return a;
  endfunction : grp_addr

  wire [63:0] pri_addr = grp_addr(hash_new, mode64_q, org_q, mask64, mask32_q);
  wire [63:0] sec_addr = grp_addr(~hash_q, m64_q, org_q, mask64, mask32_q);
  wire [63:0] ent_step = m64_q ? hpts_pkg::ENT64_BYTES : hpts_pkg::ENT32_BYTES;

  //////////////////////////////////////////////////////////////////////
  // Entry match against the latched access.
  // The 32-bit index field is six bits wide, the 64-bit one five.
  wire [5:0] api_mask = m64_q ? 6'h1f : 6'h3f;
  wire virtual_segment_id_eq = m64_q ? (ent_segment_id_i == virtual_segment_id_q) :
    (ent_segment_id_i[23:0] == virtual_segment_id_q[23:0]);
  wire api_eq = ((ent_page_index_i ^ api_q) & api_mask) == 6'h00;
  wire ent_match = ent_valid_i
    && (ent_hash_sel_i == sec_q)
    && virtual_segment_id_eq && api_eq;
  wire fetch_ok = (state_q == hpts_pkg::HPTS_FETCH) && mem_ack_i;
  wire grp_end = slot_q == hpts_pkg::LAST_SLOT;

  //////////////////////////////////////////////////////////////////////
  // Search sequencer: primary slots 0..7, then secondary slots 0..7.
  // Ascending order is one legal order and suits tables that are
  // filled from slot 0 upward, so common hits come early.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= hpts_pkg::HPTS_IDLE;
      sec_q <= 1'b0;
      slot_q <= 3'h0;
      hash_q <= 39'h0;
      m64_q <= hpts_pkg::MODE_RST;
      virtual_segment_id_q <= 52'h0;
      api_q <= 6'h00;
      addr_q <= 64'h0;
    end
    else
    begin
      case (state_q)
        hpts_pkg::HPTS_IDLE:
        begin
          if (srch_start_i)
          begin
            state_q <= hpts_pkg::HPTS_FETCH;
            sec_q <= 1'b0;
            slot_q <= 3'h0;
            hash_q <= hash_new;
            m64_q <= mode64_q;
            virtual_segment_id_q <= virtual_segment_id_i;
            api_q <= abbreviated_page_index_i;
            addr_q <= pri_addr;
          end
        end
        hpts_pkg::HPTS_FETCH:
        begin
          if (fetch_ok)
          begin
            if (ent_match || (grp_end && sec_q))
              state_q <= hpts_pkg::HPTS_DONE;
            else if (grp_end)
            begin
              sec_q <= 1'b1;
              slot_q <= 3'h0;
              addr_q <= sec_addr;
            end
            else
            begin
              slot_q <= slot_q + 3'h1;
              addr_q <= addr_q + ent_step;
            end
          end
        end
        hpts_pkg::HPTS_DONE:
          state_q <= hpts_pkg::HPTS_IDLE;
        default:
          state_q <= hpts_pkg::HPTS_IDLE;
      endcase
    end
  end

  // Result flags; the hit address names the one entry to update.
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      done_q <= 1'b0;
      hit_q <= 1'b0;
      fault_q <= 1'b0;
      hit_addr_q <= 64'h0;
    end
    else
    begin
      done_q <= fetch_ok && (ent_match || (grp_end && sec_q));
      if (srch_start_i && (state_q == hpts_pkg::HPTS_IDLE))
      begin
        hit_q <= 1'b0;
        fault_q <= 1'b0;
      end
      else if (fetch_ok && ent_match)
      begin
        hit_q <= 1'b1;
        hit_addr_q <= addr_q;
      end
      else if (fetch_ok && grp_end && sec_q)
        fault_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs.
  assign reg_rdata_o = rdata_q;
  assign mem_req_o = state_q == hpts_pkg::HPTS_FETCH;
  assign mem_addr_o = addr_q;
  assign srch_busy_o = state_q != hpts_pkg::HPTS_IDLE;
  assign srch_done_o = done_q;
  assign srch_hit_o = hit_q;
  assign srch_fault_o = fault_q;
  assign hit_entry_addr_o = hit_addr_q;

  //////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_last_sec_miss;
    fetch_ok && sec_q && grp_end && !ent_match;
  endsequence
  sequence s_fault_shown;
    srch_done_o && srch_fault_o && !srch_hit_o;
  endsequence

  low_bits_zero_a: assert property (
    mem_req_o && m64_q |-> mem_addr_o[6:4] == slot_q && mem_addr_o[3:0] == 4'h0)
    else $error("64-bit entry address misaligned");
  high_bits_32_a: assert property (
    mem_req_o && !m64_q |-> mem_addr_o[63:32] == 32'h0 && mem_addr_o[5:3] == slot_q && mem_addr_o[2:0] == 3'h0)
    else $error("32-bit entry address out of range");
  pri_addr_form_a: assert property (
    srch_start_i && !srch_busy_o && mode64_q |=>
    mem_addr_o[63:18] == ($past(org_q) | {18'h0, $past(hash64[38:11]) & $past(mask64)}))
    else $error("primary upper group bits wrong");
  pri_hash_low_a: assert property (
    srch_start_i && !srch_busy_o && mode64_q |=> mem_addr_o[17:7] == $past(hash64[10:0]))
    else $error("primary hash low bits wrong");
  sec_complement_a: assert property (
    fetch_ok && !sec_q && grp_end && !ent_match |=> sec_q && slot_q == 3'h0 &&
    (m64_q ? (mem_addr_o[17:7] == ~hash_q[10:0]) : (mem_addr_o[15:6] == ~hash_q[9:0])) &&
    mem_addr_o == grp_addr(~hash_q, m64_q, org_q, mask64, mask32_q))
    else $error("secondary group address wrong");
  fault_report_a: assert property (
    s_last_sec_miss |=> s_fault_shown)
    else $error("missed page fault");
  no_sec_after_hit_a: assert property (
    fetch_ok && ent_match |=> !mem_req_o ##1 !mem_req_o)
    else $error("search went on after hit");
  invalid_no_hit_a: assert property (
    fetch_ok && !ent_valid_i && !(grp_end && sec_q) |=> !srch_done_o && mem_req_o)
    else $error("invalid entry ended search");
  hsel_check_a: assert property (
    fetch_ok && (ent_hash_sel_i != sec_q) && !(grp_end && sec_q) |=> !srch_done_o)
    else $error("wrong hash-select accepted");
  hit_addr_a: assert property (
    fetch_ok && ent_match |=> srch_hit_o && hit_entry_addr_o == $past(mem_addr_o))
    else $error("hit address not recorded");
  step_size_a: assert property (
    fetch_ok && !ent_match && !grp_end |=> mem_addr_o == $past(mem_addr_o) + $past(ent_step))
    else $error("entry step wrong");
endmodule : hpts_search
`default_nettype wire

// file: verilog/hpts_pkg.sv
`default_nettype none
// Shared constants of the hashed page table search block.
package hpts_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] ORG_HI_OFF = 4'h0;
  localparam logic [3:0] ORG_LO_OFF = 4'h4;
  localparam logic [3:0] CTRL_OFF = 4'h8;
  localparam logic [3:0] STAT_OFF = 4'hc;
  // Field positions (little-endian bit indices of the register word).
  localparam int ORG_LO_W = 14;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_SIZE_LSB = 8;
  localparam int CTRL_MASK_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_HIT_BIT = 2;
  localparam int STAT_SEC_BIT = 3;
  localparam int STAT_SLOT_LSB = 4;
  // Reset values.
  localparam logic [45:0] ORG_RST = 46'h0;
  localparam logic [4:0] SIZE_RST = 5'h00;
  localparam logic [8:0] MASK_RST = 9'h000;
  localparam logic MODE_RST = 1'b1;
  // Field widths of the table and hash.
  localparam int ORG_W = 46;
  localparam int HASH_W = 39;
  localparam int HASH32_W = 19;
  localparam int PIDX_W = 16;
  localparam int VIRTUAL_SEGMENT_ID_W = 52;
  localparam int API_W = 6;
  localparam int HI64_W = 28;
  localparam int HI32_W = 9;
  // Entries per group and entry sizes in bytes.
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [63:0] ENT64_BYTES = 64'h10;
  localparam logic [63:0] ENT32_BYTES = 64'h8;
  // Search states.
  typedef enum logic [1:0] {HPTS_IDLE, HPTS_FETCH, HPTS_DONE} hpts_state_t;
endpackage : hpts_pkg
`default_nettype wire

// file: tb/hpts_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module hpts_mem_model (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Entry fetch request.
  input wire logic req_i,
  input wire logic [63:0] addr_i,
  // Decoded entry answer.
  output logic ack_o,
  output logic valid_o,
  output logic hsel_o,
  output logic [51:0] seg_o,
  output logic [5:0] api_o
);
  logic [59:0] ents [logic [63:0]];
  logic [63:0] log_q [$];
  logic [63:0] pat_q = 64'h0;
  logic [59:0] word;
  int lat = 0;
  int cnt_q = 0;
  ////////////////////////////////////////
  // Zero latency answers in the request cycle; empty memory reads as an invalid entry.
  assign ack_o = req_i && (cnt_q >= lat);
  // Outside an answer the fields churn, so stale data never passes for a real entry.
  always @*
  begin
    if (ack_o)
      word = ents.exists(addr_i) ? ents[addr_i] : 60'h0;
    else
      word = pat_q[59:0];
  end
  assign {valid_o, hsel_o, seg_o, api_o} = word;
  // Wait counter, churn pattern and a log of every answered address.
  always @(posedge ref_clk_i)
  begin
    pat_q <= ~(pat_q + 64'h1);
    cnt_q <= (sys_rst_i || !req_i || ack_o) ? 0 : cnt_q + 1;
    if (!sys_rst_i && ack_o)
      log_q.push_back(addr_i);
  end
  ////////////////////////////////////////
  // Places one entry at a byte address.
  task automatic put(input logic [63:0] a, input logic v, input logic h, input logic [51:0] s, input logic [5:0] p);
    ents[a] = {v, h, s, p};
  endtask : put
endmodule : hpts_mem_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic start = 1'b0;
  logic [51:0] virtual_segment_id = 52'h0;
  logic [15:0] pidx = 16'h0;
  logic [5:0] abbreviated_page_index = 6'h0;
  logic busy, done, hit, fault, req, ack, ev, eh;
  logic [63:0] hadr, madr, pg, sg, step;
  logic [51:0] es;
  logic [5:0] ea;
  logic [45:0] org = 46'h0123_4567_89a0;
  logic [51:0] v1 = 52'h1_2345_6789_abcd;
  int failures = 0;
  int total_checks = 0;
  hpts_search hpts_search_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .srch_start_i(start), .virtual_segment_id_i(virtual_segment_id), .page_index_i(pidx), .abbreviated_page_index_i(abbreviated_page_index),
    .srch_busy_o(busy), .srch_done_o(done), .srch_hit_o(hit), .srch_fault_o(fault), .hit_entry_addr_o(hadr),
    .mem_req_o(req), .mem_addr_o(madr), .mem_ack_i(ack), .ent_valid_i(ev), .ent_hash_sel_i(eh),
    .ent_segment_id_i(es), .ent_page_index_i(ea));
  hpts_mem_model hpts_mem_model_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req),
    .addr_i(madr), .ack_o(ack), .valid_o(ev), .hsel_o(eh), .seg_o(es), .api_o(ea));
  // Free-running 40 MHz clock.
  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(64'(reg_rdata_o), 64'(e));
  endtask : rdc
  function automatic logic [63:0] grp(input logic [38:0] h, input logic m64, input logic [27:0] m,
    input logic [8:0] mk);
    if (m64)
      return {org[45:28], org[27:0] | (h[38:11] & m), h[10:0], 7'h00};
    return {32'h0, org[15:9], org[8:0] | (h[18:10] & mk), h[9:0], 6'h00};
  endfunction : grp
  // Works out both group addresses and clears memory before each search.
  task automatic setup(input logic [15:0] p, input logic [5:0] a, input logic m64, input logic [4:0] n,
    input logic [8:0] mk);
    logic [38:0] h;
    @(posedge ref_clk_i);
    virtual_segment_id <= v1;
    pidx <= p;
    abbreviated_page_index <= a;
    h = m64 ? v1[38:0] ^ {23'h0, p} : {20'h0, v1[18:0] ^ {3'h0, p}};
    pg = grp(h, m64, 28'((64'h1 << n) - 64'h1), mk);
    sg = grp(~h, m64, 28'((64'h1 << n) - 64'h1), mk);
    step = m64 ? 64'h10 : 64'h8;
    hpts_mem_model_inst.ents.delete();
    hpts_mem_model_inst.log_q.delete();
  endtask : setup
  task automatic pt(input int s, input logic sec, input logic v, input logic h, input logic [51:0] sd,
    input logic [5:0] a);
    hpts_mem_model_inst.put((sec ? sg : pg) + step * s, v, h, sd, a);
  endtask : pt
  // Launches one search and checks every fetch address and the outcome.
  task automatic run(input int nf, input logic e);
    int i;
    @(posedge ref_clk_i);
    start <= 1'b1;
    // The second start cycle falls while busy and must be ignored.
    repeat (2) @(posedge ref_clk_i);
    start <= 1'b0;
    #1;
    i = 0;
    while (done !== 1'b1)
    begin
      @(posedge ref_clk_i);
      #1;
      i++;
      if (i > 200)
      begin
        failures++;
        close_out();
      end
    end
    chk({hit, fault, req, busy}, {e, !e, 1'b0, 1'b1});
    chk(hpts_mem_model_inst.log_q.size(), nf);
    for (i = 0; i < hpts_mem_model_inst.log_q.size(); i++)
      chk(hpts_mem_model_inst.log_q[i], (i < 8 ? pg : sg) + step * (i % 8));
    if (e)
      chk(hadr, (nf > 8 ? sg : pg) + step * ((nf - 1) % 8));
  endtask : run
  ////////////////////////////////////////
  // Main sequence: reset, registers, then searches in both modes.
  initial
  begin
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rdc(4'h8, 32'h1);
    rdc(4'h0, 32'h0);
    wr(4'hc, 32'hffff_ffff);
    rdc(4'hc, 32'h0);
    rdc(4'h2, 32'h0);
    wr(4'h0, org[45:14]);
    wr(4'h4, {18'h0, org[13:0]});
    wr(4'h8, 32'h0000_0401);
    rdc(4'h0, org[45:14]);
    rdc(4'h4, {18'h0, org[13:0]});
    rdc(4'h8, 32'h0000_0401);
    hpts_mem_model_inst.lat = 1;
    setup(16'hbeef, 6'h15, 1'b1, 5'h4, 9'h000);
    pt(0, 0, 1, 0, v1, 6'h14);
    pt(1, 0, 1, 0, v1 ^ 52'h1, 6'h15);
    pt(2, 0, 1, 1, v1, 6'h15);
    pt(3, 0, 0, 0, v1, 6'h15);
    pt(4, 0, 1, 0, v1, 6'h35);
    pt(6, 0, 1, 0, v1, 6'h15);
    run(5, 1'b1);
    rdc(4'hc, 32'h44);
    hpts_mem_model_inst.lat = 0;
    setup(16'h1234, 6'h04, 1'b1, 5'h4, 9'h000);
    pt(7, 0, 1, 0, v1 ^ 52'h8, 6'h04);
    pt(5, 1, 1, 1, v1, 6'h04);
    run(14, 1'b1);
    rdc(4'hc, 32'h5c);
    setup(16'h0f0f, 6'h21, 1'b1, 5'h4, 9'h000);
    pt(2, 1, 1, 0, v1, 6'h21);
    run(16, 1'b0);
    wr(4'h8, 32'h0003_0000);
    setup(16'h5a5a, 6'h3f, 1'b0, 5'h0, 9'h003);
    pt(0, 0, 1, 1, v1, 6'h3f);
    pt(1, 1, 1, 1, v1, 6'h3f);
    run(10, 1'b1);
    close_out();
  end
endmodule : tb
`default_nettype wire
